// ==== rtl/dem_pkg.sv ====
// Shared constants and types for the DRAM error mask and message routing block
package dem_pkg;

  // APB address width and data width
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Log, class and interrupt widths, and the number of message types
  localparam int unsigned LOG_W  = 16;
  localparam int unsigned CLS_W  = 8;
  localparam int unsigned IRQ_W  = 4;
  localparam int unsigned NMSG   = 3;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIRST_LOG = 8'h80;
  localparam logic [7:0] IDX_NEXT_LOG  = 8'h82;
  localparam logic [7:0] IDX_CLS_MASK  = 8'h84;
  localparam logic [7:0] IDX_SCI_EN    = 8'h88;
  localparam logic [7:0] IDX_SMI_EN    = 8'h8A;
  localparam logic [7:0] IDX_SERR_EN   = 8'h8C;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h91;

  localparam logic [ADDR_W-1:0] ADDR_FIRST_LOG = {2'h0, IDX_FIRST_LOG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_NEXT_LOG  = {2'h0, IDX_NEXT_LOG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CLS_MASK  = {2'h0, IDX_CLS_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SCI_EN    = {2'h0, IDX_SCI_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SMI_EN    = {2'h0, IDX_SMI_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SERR_EN   = {2'h0, IDX_SERR_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = {2'h0, IDX_IRQ_MASK, 2'h0};

  // Reset values
  localparam logic [LOG_W-1:0] LOG_RST      = 16'h0000;
  localparam logic [CLS_W-1:0] CLS_MASK_RST = 8'h00;
  localparam logic [CLS_W-1:0] MSG_EN_RST   = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST      = 4'h0;

  // Error class bit positions within one channel byte
  localparam int unsigned CLS_CORR_RD    = 0;
  localparam int unsigned CLS_UNCORR_RD  = 1;
  localparam int unsigned CLS_SCRUB_ERR  = 2;
  localparam int unsigned CLS_THRESHOLD  = 3;
  localparam int unsigned CLS_COPY_DONE  = 4;
  localparam int unsigned CLS_DBL_RETRY  = 5;
  localparam int unsigned CLS_POISON_WR  = 6;
  localparam int unsigned CLS_TEST_DONE  = 7;

  // Channel B occupies the upper byte of each log
  localparam int unsigned CHB_OFS = 8;

  // Interrupt status bit positions
  localparam int unsigned IRQ_SCI_SENT  = 0;
  localparam int unsigned IRQ_SMI_SENT  = 1;
  localparam int unsigned IRQ_SERR_SENT = 2;
  localparam int unsigned IRQ_LOGGED    = 3;

  // Message type encodings on the special-cycle port
  localparam logic [1:0] MSG_SERR = 2'h0;
  localparam logic [1:0] MSG_SMI  = 2'h1;
  localparam logic [1:0] MSG_SCI  = 2'h2;

  // Index of each message type in the generator vectors
  localparam int unsigned MI_SERR = 0;
  localparam int unsigned MI_SMI  = 1;
  localparam int unsigned MI_SCI  = 2;

  typedef enum logic [0:0] {DEM_IDLE, DEM_SEND} dem_msg_state_e;

  // Fold a channel A/B log into one class vector
  function automatic logic [CLS_W-1:0] dem_fold(input logic [LOG_W-1:0] v);
    dem_fold = v[LOG_W-1:CHB_OFS] | v[CLS_W-1:0];
  endfunction

endpackage

// ==== rtl/dem_log.sv ====
// Sticky write-one-to-clear error log that survives the bus reset
`timescale 1ns/10ps
`default_nettype none
module dem_log
  import dem_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             por_n,
  input  wire logic             ce,
  input  wire logic [LOG_W-1:0] set_bits,
  input  wire logic [LOG_W-1:0] clr_bits,
  output logic      [LOG_W-1:0] log_q
);

  logic [LOG_W-1:0] log_d;

  // A new event in the clear cycle wins over the clear
  assign log_d = (log_q & ~clr_bits) | set_bits;

  // Only power-on clears it, the bus reset does not
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      log_q <= LOG_RST;
    end else if (ce) begin
      log_q <= log_d;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/dem_msg_gen.sv ====
// Special-cycle message sequencer toward the I/O hub
`timescale 1ns/10ps
`default_nettype none
module dem_msg_gen
  import dem_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic [NMSG*CLS_W-1:0] req_lvl,
  output logic                       msg_valid,
  input  wire logic                  msg_ready,
  output logic      [1:0]            msg_type,
  output logic      [CLS_W-1:0]      msg_class,
  output logic      [NMSG-1:0]       sent
);

  logic [NMSG*CLS_W-1:0] prev_q;
  logic [NMSG*CLS_W-1:0] pend_q;
  logic [NMSG*CLS_W-1:0] pend_d;
  logic [NMSG*CLS_W-1:0] take;
  logic [NMSG-1:0]       any_pend;
  logic [NMSG-1:0]       pick;
  logic [NMSG-1:0]       cur_q;
  dem_msg_state_e        state_q;
  dem_msg_state_e        state_d;

  genvar g;
  generate
    for (g = 0; g < NMSG; g = g + 1) begin : g_type
      assign any_pend[g] = |pend_q[g*CLS_W +: CLS_W];
      assign take[g*CLS_W +: CLS_W] = {CLS_W{pick[g]}} & pend_q[g*CLS_W +: CLS_W];
    end
  endgenerate

  // Fatal-class messages go first when several types are waiting
  always_comb begin
    pick = '0;
    if (state_q == DEM_IDLE) begin
      if (any_pend[MI_SERR]) begin
        pick[MI_SERR] = 1'b1;
      end else if (any_pend[MI_SMI]) begin
        pick[MI_SMI] = 1'b1;
      end else if (any_pend[MI_SCI]) begin
        pick[MI_SCI] = 1'b1;
      end
    end
  end

  // A class asserting again while its message is queued merges into it
  assign pend_d = (pend_q & ~take) | (req_lvl & ~prev_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      pend_q <= '0;
    end else if (ce) begin
      prev_q <= req_lvl;
      pend_q <= pend_d;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      DEM_IDLE: begin
        if (|pick) begin
          state_d = DEM_SEND;
        end
      end
      DEM_SEND: begin
        if (msg_ready) begin
          state_d = DEM_IDLE;
        end
      end
      default: begin
        state_d = DEM_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DEM_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_type  <= MSG_SERR;
      msg_class <= '0;
      cur_q     <= '0;
    end else if (ce && (|pick)) begin
      cur_q <= pick;
      if (pick[MI_SERR]) begin
        msg_type  <= MSG_SERR;
        msg_class <= take[MI_SERR*CLS_W +: CLS_W];
      end else if (pick[MI_SMI]) begin
        msg_type  <= MSG_SMI;
        msg_class <= take[MI_SMI*CLS_W +: CLS_W];
      end else begin
        msg_type  <= MSG_SCI;
        msg_class <= take[MI_SCI*CLS_W +: CLS_W];
      end
    end
  end

  assign msg_valid = (state_q == DEM_SEND);
  assign sent      = (msg_valid && msg_ready && ce) ? cur_q : '0;

endmodule
`default_nettype wire

// ==== rtl/dem_top.sv ====
// DRAM error logs, class masks and message enables behind an APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RQ1: Next-error log is 16 bits, zero at power-up, same layout, write one clears.
// RQ2: Masked class is neither logged nor signalled by interrupt or message.
// RQ3: One mask bit covers its class on both channels A and B.
// RQ4: Mask survives bus reset; power-up value is all zeros, allowing all.
// RQ5: Mask bits 7,6,5 gate test-done, poisoned write, double-error retry.
// RQ6: Mask bits 4,3,2 gate copy-done, correctable threshold, scrub uncorrectable.
// RQ7: Mask bit 1 gates uncorrectable read, bit 0 correctable read.
// RQ8: SCI enable register is 8 bits, read/write, zero after reset.
// RQ9: SCI message when log bit n or n+8 set and SCI enable n set.
// RQ10: Any set log flag can raise SERR, SMI or SCI per its enable.
// RQ11: Software enables at most one message type per class.
// RQ12: Each SCI enable bit covers its class on both channels.
// RQ13: Channel A classes in bits 7..0, channel B in 15..8.
// RQ14: Log bits clear only by writing one, keep value through bus reset.
// RQ15: Later errors land in the next-error log once first log holds one.
// RQ16: Masked class logs nothing and so produces no message at all.
module dem_top
  import dem_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              por_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [CLS_W-1:0]  err_evt_a,
  input  wire logic [CLS_W-1:0]  err_evt_b,
  output logic                   msg_valid,
  input  wire logic              msg_ready,
  output logic      [1:0]        msg_type,
  output logic      [CLS_W-1:0]  msg_class,
  output logic                   irq
);

  logic [LOG_W-1:0]      raw_evt;
  logic [LOG_W-1:0]      gated_evt;
  logic                  first_empty;
  logic [LOG_W-1:0]      first_set;
  logic [LOG_W-1:0]      next_set;
  logic [LOG_W-1:0]      first_clr;
  logic [LOG_W-1:0]      next_clr;
  logic [LOG_W-1:0]      first_q;
  logic [LOG_W-1:0]      next_q;
  logic [CLS_W-1:0]      cls_mask_q;
  logic [CLS_W-1:0]      sci_en_q;
  logic [CLS_W-1:0]      smi_en_q;
  logic [CLS_W-1:0]      serr_en_q;
  logic [IRQ_W-1:0]      irq_stat_q;
  logic [IRQ_W-1:0]      irq_stat_d;
  logic [IRQ_W-1:0]      irq_mask_q;
  logic [IRQ_W-1:0]      irq_set;
  logic [IRQ_W-1:0]      irq_rd_seen_q;
  logic [CLS_W-1:0]      logged_cls;
  logic [NMSG*CLS_W-1:0] req_lvl;
  logic [NMSG-1:0]       sent;
  logic                  setup;
  logic                  access;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  hit;
  logic [DATA_W-1:0]     rd_mux;
  logic [DATA_W-1:0]     prdata_q;
  logic                  pslverr_q;

  // APB slave

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite && ce;
  assign rd_acc = access && !pwrite && ce;

  // Every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    hit    = 1'b1;
    rd_mux = '0;
    case (paddr)
      ADDR_FIRST_LOG: rd_mux[LOG_W-1:0] = first_q;
      ADDR_NEXT_LOG:  rd_mux[LOG_W-1:0] = next_q;
      ADDR_CLS_MASK:  rd_mux[CLS_W-1:0] = cls_mask_q;
      ADDR_SCI_EN:    rd_mux[CLS_W-1:0] = sci_en_q;
      ADDR_SMI_EN:    rd_mux[CLS_W-1:0] = smi_en_q;
      ADDR_SERR_EN:   rd_mux[CLS_W-1:0] = serr_en_q;
      ADDR_IRQ_STAT:  rd_mux[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK:  rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:        hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (ce && setup) begin
      prdata_q  <= pwrite ? '0 : rd_mux;
      pslverr_q <= !hit;
    end
  end

  // Remember which status bits the pending read returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_rd_seen_q <= IRQ_RST;
    end else if (ce && setup) begin
      irq_rd_seen_q <= (!pwrite && paddr == ADDR_IRQ_STAT) ? irq_stat_q : IRQ_RST;
    end
  end

  // Class masking and logging

  // Channel A in the low byte, channel B in the high byte
  assign raw_evt = {err_evt_b, err_evt_a}; // see RQ13

  // One mask byte gates both channel bytes
  assign gated_evt = raw_evt & ~{cls_mask_q, cls_mask_q}; // see RQ2 see RQ3 see RQ5 see RQ6 see RQ7 see RQ16

  assign first_empty = (first_q == LOG_RST);

  // Events seen while the first log is empty all go to it; later ones go to next
  assign first_set = first_empty ? gated_evt : LOG_RST;
  assign next_set  = first_empty ? LOG_RST : gated_evt; // see RQ15

  assign first_clr = (wr_acc && paddr == ADDR_FIRST_LOG) ? pwdata[LOG_W-1:0] : LOG_RST; // see RQ14
  assign next_clr  = (wr_acc && paddr == ADDR_NEXT_LOG) ? pwdata[LOG_W-1:0] : LOG_RST; // see RQ14

  dem_log u_first_log (
    .pclk     (pclk),
    .por_n    (por_n),
    .ce       (ce),
    .set_bits (first_set),
    .clr_bits (first_clr),
    .log_q    (first_q)
  );

  // Sticky through bus reset, cleared only at power-up or by writing one
  dem_log u_next_log (
    .pclk     (pclk),
    .por_n    (por_n),
    .ce       (ce),
    .set_bits (next_set),
    .clr_bits (next_clr),
    .log_q    (next_q)
  ); // see RQ1

  // Configuration registers

  // Mask keeps its contents across the bus reset
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cls_mask_q <= CLS_MASK_RST;
    end else if (wr_acc && paddr == ADDR_CLS_MASK) begin
      cls_mask_q <= pwdata[CLS_W-1:0]; // see RQ4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sci_en_q <= MSG_EN_RST;
    end else if (wr_acc && paddr == ADDR_SCI_EN) begin
      sci_en_q <= pwdata[CLS_W-1:0]; // see RQ8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_en_q <= MSG_EN_RST;
    end else if (wr_acc && paddr == ADDR_SMI_EN) begin
      smi_en_q <= pwdata[CLS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_en_q <= MSG_EN_RST;
    end else if (wr_acc && paddr == ADDR_SERR_EN) begin
      serr_en_q <= pwdata[CLS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= IRQ_RST;
    end else if (wr_acc && paddr == ADDR_IRQ_MASK) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // Message routing

  // Flags from either log and either channel fold onto one class vector
  assign logged_cls = dem_fold(first_q) | dem_fold(next_q); // see RQ12

  // Software keeps the three enables disjoint; overlap would send each type
  assign req_lvl[MI_SERR*CLS_W +: CLS_W] = logged_cls & serr_en_q; // see RQ10 see RQ11
  assign req_lvl[MI_SMI*CLS_W +: CLS_W]  = logged_cls & smi_en_q; // see RQ10
  assign req_lvl[MI_SCI*CLS_W +: CLS_W]  = logged_cls & sci_en_q; // see RQ9

  dem_msg_gen u_msg_gen (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .req_lvl   (req_lvl),
    .msg_valid (msg_valid),
    .msg_ready (msg_ready),
    .msg_type  (msg_type),
    .msg_class (msg_class),
    .sent      (sent)
  );

  // Interrupt status

  always_comb begin
    irq_set                = IRQ_RST;
    irq_set[IRQ_SCI_SENT]  = sent[MI_SCI];
    irq_set[IRQ_SMI_SENT]  = sent[MI_SMI];
    irq_set[IRQ_SERR_SENT] = sent[MI_SERR];
    irq_set[IRQ_LOGGED]    = |gated_evt;
  end

  // A read clears only what it returned; a new event in that cycle still sets
  assign irq_stat_d = (irq_stat_q & ~(rd_acc && paddr == ADDR_IRQ_STAT ? irq_rd_seen_q : IRQ_RST)) | irq_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= IRQ_RST;
    end else if (ce) begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// ==== testbench/dem_hub_model.sv ====
// Hub-side receiver of special-cycle messages, prompt or stalling
`timescale 1ns/10ps
`default_nettype none
module dem_hub_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic msg_valid,
  output logic      msg_ready
);
  logic [1:0] cnt_q;
  // Slow mode takes one cycle in four, so the sender must hold its offer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 2'h0;
      msg_ready <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      msg_ready <= msg_valid && (!slow || cnt_q == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/dem_top_chk.sv ====
// Port-level assertions for the DRAM error mask and message block
`timescale 1ns/10ps
`default_nettype none
module dem_top_chk
  import dem_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              por_n,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              msg_valid,
  input wire logic              msg_ready,
  input wire logic [1:0]        msg_type,
  input wire logic [CLS_W-1:0]  msg_class
);
  logic [CLS_W-1:0] mask_q;
  logic [CLS_W-1:0] sci_q;
  wire              wr_acc = psel && penable && pwrite && ce;
  wire              mapped = paddr inside {ADDR_FIRST_LOG, ADDR_NEXT_LOG, ADDR_CLS_MASK, ADDR_SCI_EN,
                                           ADDR_SMI_EN, ADDR_SERR_EN, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
  // The mask shadow ignores the bus reset, as the real mask must
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) mask_q <= 8'h00;
    else if (wr_acc && paddr == ADDR_CLS_MASK) mask_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sci_q <= 8'h00;
    else if (wr_acc && paddr == ADDR_SCI_EN) sci_q <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_offer; msg_valid && !msg_ready; endsequence
  sequence s_take; msg_valid && msg_ready && ce; endsequence
  sequence s_rd(a); psel && penable && !pwrite && paddr == a; endsequence
  AST_PREADY: assert property (psel |-> pready) else $error("pready low");
  AST_MAPPED: assert property (psel && penable && mapped |-> !pslverr) else $error("error on mapped");
  AST_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  AST_WR_ZERO: assert property (psel && penable && pwrite |-> prdata == 32'h0) else $error("write data out");
  AST_MASK_RD: assert property (s_rd(ADDR_CLS_MASK) |-> prdata == {24'h000000, mask_q})
    else $error("mask readback");
  AST_SCI_RD: assert property (s_rd(ADDR_SCI_EN) |-> prdata == {24'h000000, sci_q})
    else $error("sci enable readback");
  AST_HOLD: assert property (s_offer |=> msg_valid && $stable(msg_type) && $stable(msg_class))
    else $error("message dropped");
  AST_GAP: assert property (s_take |=> !msg_valid) else $error("no idle after accept");
  AST_MASKED: assert property (msg_valid |-> msg_class != 8'h00 && (msg_class & mask_q) == 8'h00)
    else $error("masked class sent");
  AST_SCI_EN: assert property (msg_valid && msg_type == MSG_SCI |-> (msg_class & ~sci_q) == 8'h00)
    else $error("sci not enabled");
endmodule
bind dem_top dem_top_chk u_chk (.pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_type(msg_type), .msg_class(msg_class));
`default_nettype wire

// ==== testbench/test_dram_error_mask_sci_route.sv ====
// Self-checking bench for the DRAM error mask and message block
`timescale 1ns/10ps
`default_nettype none
module test_dram_error_mask_sci_route
  import dem_pkg::*;
;
  logic              pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, ce = 1;
  logic              pready, pslverr, msg_valid, msg_ready, irq;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic [CLS_W-1:0]  err_evt_a = '0, err_evt_b = '0, msg_class;
  logic [1:0]        msg_type;
  logic [15:0]       nlog;
  logic [31:0]       q_rd[$];
  logic [9:0]        q_msg[$];
  int                n_mismatch = 0, cmp_count = 0, seed = 96, k, t;
  always #5 pclk = ~pclk;
  dem_top dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_evt_a(err_evt_a), .err_evt_b(err_evt_b), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_type(msg_type), .msg_class(msg_class), .irq(irq));
  dem_hub_model hub (.pclk(pclk), .presetn(presetn), .slow(slow), .msg_valid(msg_valid), .msg_ready(msg_ready));
  task report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sampled mid-cycle, where the combinational irq has settled
  task chk_irq(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk("prdata", q_rd.pop_front(), prdata);
    if (msg_valid === 1'b1 && msg_ready === 1'b1 && ce)
      chk("message", q_msg.size() ? q_msg.pop_front() : 32'hFFFFFFFF, {22'h0, msg_type, msg_class});
  end
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin n_mismatch++; report_and_stop(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e); q_rd.push_back(e); apb(1'b0, a, '0); endtask
  // One-cycle event pulse; waits for every expected message, then settles
  task evt(input logic ch, input int c, input logic [9:0] exp, input logic want);
    int n;
    if (want) q_msg.push_back(exp);
    if (ch) err_evt_b <= 8'h01 << c; else err_evt_a <= 8'h01 << c;
    @(posedge pclk) begin err_evt_a <= 8'h00; err_evt_b <= 8'h00; end
    for (n = 0; n < 60; n++) begin
      @(posedge pclk);
      if (q_msg.size() == 0) break;
    end
    if (n == 60) begin n_mismatch++; report_and_stop(); end
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1; por_n <= 1'b1;
    @(posedge pclk);
    rd(ADDR_NEXT_LOG, 32'h0);
    rd(ADDR_CLS_MASK, 32'h0);
    rd(ADDR_SCI_EN, 32'h0);
    rd(12'hFFC, 32'h0);
    for (k = 0; k < 4; k++) begin
      t = $random(seed);
      wr(ADDR_CLS_MASK, t); rd(ADDR_CLS_MASK, t & 255);
      wr(ADDR_SCI_EN, ~t); rd(ADDR_SCI_EN, ~t & 255);
    end
    wr(ADDR_CLS_MASK, 32'h0); wr(ADDR_SCI_EN, 32'hFF);
    evt(1'b0, 0, {MSG_SCI, 8'h01}, 1'b1);
    rd(ADDR_FIRST_LOG, 32'h0001);
    nlog = 16'h0;
    for (k = 1; k < 8; k++) begin
      evt(k[0], k, {MSG_SCI, 8'h01 << k}, 1'b1);
      nlog |= k[0] ? 16'h0100 << k : 16'h0001 << k;
    end
    rd(ADDR_NEXT_LOG, nlog);
    wr(ADDR_NEXT_LOG, 32'h0); rd(ADDR_NEXT_LOG, nlog);
    wr(ADDR_NEXT_LOG, 32'hFFFF); wr(ADDR_FIRST_LOG, 32'hFFFF); rd(ADDR_NEXT_LOG, 32'h0);
    for (k = 0; k < 8; k++) begin
      wr(ADDR_CLS_MASK, 32'h1 << k);
      evt(1'b0, k, 10'h0, 1'b0); evt(1'b1, k, 10'h0, 1'b0);
      rd(ADDR_FIRST_LOG, 32'h0);
      rd(ADDR_NEXT_LOG, 32'h0);
    end
    wr(ADDR_CLS_MASK, 32'hFE);
    evt(1'b1, 0, {MSG_SCI, 8'h01}, 1'b1);
    slow <= 1'b1;
    wr(ADDR_CLS_MASK, 32'h0); wr(ADDR_SCI_EN, 32'h0);
    wr(ADDR_SMI_EN, 32'h04); evt(1'b0, 2, {MSG_SMI, 8'h04}, 1'b1);
    wr(ADDR_SMI_EN, 32'h0); wr(ADDR_SERR_EN, 32'h08); evt(1'b1, 3, {MSG_SERR, 8'h08}, 1'b1);
    wr(ADDR_CLS_MASK, 32'h80);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CLS_MASK, 32'h80);
    rd(ADDR_SCI_EN, 32'h0);
    rd(ADDR_NEXT_LOG, 32'h0804);
    evt(1'b0, 4, 10'h0, 1'b0);
    // Clock enable low drops the event and freezes the log
    ce <= 1'b0;
    evt(1'b0, 5, 10'h0, 1'b0);
    ce <= 1'b1;
    rd(ADDR_NEXT_LOG, 32'h0814);
    chk_irq(1'b0);
    wr(ADDR_IRQ_MASK, 32'h8);
    chk_irq(1'b1);
    rd(ADDR_IRQ_STAT, 32'h8);
    chk_irq(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
